// *** design/rom_loader_pkg.sv ***
package rom_loader_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LINK_CLK_PERIOD_NS = 160;
  // Quarter of a 100 kHz two-wire bit period
  localparam int TWI_QUARTER_NS     = 2500;
  // Least time, so the count rounds up
  localparam int TWI_QUARTER_CYC    =
    (TWI_QUARTER_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Image layout (byte offsets in the serial memory)
  // ----------------------------------------------------------------
  localparam logic [7:0] IMG_FIRST      = 8'h00;
  localparam logic [7:0] IMG_LAST       = 8'h7e;
  localparam logic [7:0] OFS_LINK_REGS  = 8'h26;
  localparam logic [7:0] OFS_ROM_HEADER = 8'h28;
  localparam logic [7:0] OFS_BUS_OPTION = 8'h2c;
  localparam logic [7:0] OFS_GUID_HIGH  = 8'h30;
  localparam logic [7:0] OFS_GUID_LOW   = 8'h34;
  localparam logic [7:0] OFS_SLOT_SD    = 8'h38;
  localparam logic [7:0] OFS_SD_SUBSYS  = 8'h3c;
  localparam logic [7:0] OFS_SD_CAP     = 8'h48;
  localparam logic [7:0] OFS_SD_MAXCUR  = 8'h4c;
  localparam logic [7:0] OFS_SD_MAXEND  = 8'h4e;
  localparam logic [7:0] OFS_SLOT_MMC   = 8'h50;
  localparam logic [7:0] OFS_MMC_SUBSYS = 8'h54;
  localparam logic [7:0] OFS_SLOT_MS    = 8'h68;
  localparam logic [7:0] OFS_MS_SUBSYS  = 8'h6c;
  localparam logic [7:0] OFS_SLOT_XD    = 8'h74;
  localparam logic [7:0] OFS_XD_SUBSYS  = 8'h74;
  localparam logic [7:0] OFS_LNK_SUBSYS = 8'h00;
  localparam logic [7:0] WORD_MASK      = 8'hfc;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEST_LINK_CFG = 3'b000,
    DEST_LINK_REG = 3'b001,
    DEST_SD       = 3'b010,
    DEST_MMC      = 3'b011,
    DEST_MS       = 3'b100,
    DEST_XD       = 3'b101
  } dest_t;

  typedef enum logic [2:0] {
    KIND_OTHER      = 3'b000,
    KIND_SUBSYS_ID  = 3'b001,
    KIND_ROM_HEADER = 3'b010,
    KIND_BUS_OPTION = 3'b011,
    KIND_GUID_HIGH  = 3'b100,
    KIND_GUID_LOW   = 3'b101,
    KIND_CAPABILITY = 3'b110,
    KIND_MAX_CURR   = 3'b111
  } kind_t;

  typedef struct packed {
    logic       valid;
    dest_t      dest;
    kind_t      kind;
    logic [7:0] offset;
    logic [7:0] data;
  } cfg_write_t;

  typedef enum logic [1:0] {
    M_WAIT_PCIRST = 2'b00,
    M_LOAD        = 2'b01,
    M_DONE        = 2'b10
  } main_state_t;

  typedef enum logic [2:0] {
    L_IDLE  = 3'b000,
    L_START = 3'b001,
    L_TX    = 3'b010,
    L_RX    = 3'b011,
    L_STOP  = 3'b100,
    L_END   = 3'b101
  } link_state_t;

endpackage : rom_loader_pkg

// *** design/serial_rom_config_loader.sv ***
`timescale 1ns/10ps

module serial_rom_config_loader
  import rom_loader_pkg::*;
#(
  parameter logic [6:0] ROM_DEV_ADDR = 7'h50
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic link_clk_in,
  input  wire logic pci_reset_n_in,
  input  wire logic rom_strap_pin_in,
  input  wire logic user_pin_4_in,
  output logic      user_pin_3_out,
  output logic      user_pin_3_oe_out,
  output logic      user_pin_4_out,
  output logic      user_pin_4_oe_out,
  output logic      rom_pins_active_out,
  output logic      target_retry_out,
  output logic      load_done_out,
  output logic      load_error_out,
  output cfg_write_t cfg_write_out
);

  localparam logic [4:0] Q_LAST = 5'(TWI_QUARTER_CYC - 1);

  // ----------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------
  typedef struct packed {
    main_state_t st;
    logic        pcirst_s1;
    logic        pcirst_s2;
    logic        pcirst_seen;
    logic        strap_s1;
    logic        strap_s2;
    logic        done_s1;
    logic        done_s2;
    logic        err_s1;
    logic        err_s2;
    logic        tog_s1;
    logic        tog_s2;
    logic        tog_prev;
    logic [7:0]  idx;
    logic        start;
    logic        retry;
    logic        pin_mux;
    logic        load_done;
    logic        load_err;
    cfg_write_t  wr;
  } main_t;

  typedef struct packed {
    link_state_t st;
    logic        rst_s1;
    logic        rst_s2;
    logic        go_s1;
    logic        go_s2;
    logic        sda_s1;
    logic        sda_s2;
    logic [4:0]  cnt;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic [7:0]  idx;
    logic [1:0]  stage;
    logic        ack_ok;
    logic        scl_oe;
    logic        sda_oe;
    logic        pin_lo;
    logic [7:0]  rx_byte;
    logic        tog;
    logic        done;
    logic        err;
  } link_t;

  main_t m_q, m_d;
  link_t l_q, l_d;
  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  function automatic dest_t dest_of(input logic [7:0] a);
    if (a < OFS_LINK_REGS)     return DEST_LINK_CFG;
    else if (a < OFS_SLOT_SD)  return DEST_LINK_REG;
    else if (a < OFS_SLOT_MMC) return DEST_SD;
    else if (a < OFS_SLOT_MS)  return DEST_MMC;
    else if (a < OFS_SLOT_XD)  return DEST_MS;
    else                       return DEST_XD;
  endfunction : dest_of

  function automatic kind_t kind_of(input logic [7:0] a);
    logic [7:0] w;
    w = a & WORD_MASK;
    if (w inside {OFS_LNK_SUBSYS, OFS_SD_SUBSYS, OFS_MMC_SUBSYS,
                  OFS_MS_SUBSYS, OFS_XD_SUBSYS})
      return KIND_SUBSYS_ID;
    else if (w == OFS_ROM_HEADER) return KIND_ROM_HEADER;
    else if (w == OFS_BUS_OPTION) return KIND_BUS_OPTION;
    else if (w == OFS_GUID_HIGH)  return KIND_GUID_HIGH;
    else if (w == OFS_GUID_LOW)   return KIND_GUID_LOW;
    else if (w == OFS_SD_CAP)     return KIND_CAPABILITY;
    else if (a >= OFS_SD_MAXCUR && a <= OFS_SD_MAXEND)
      return KIND_MAX_CURR;
    else return KIND_OTHER;
  endfunction : kind_of

  // ----------------------------------------------------------------
  // Reference clock side: strap, retry and field writes
  // ----------------------------------------------------------------
  always_comb begin
    m_d          = m_q;
    m_d.wr.valid = 1'b0;
    case (m_q.st)
      M_WAIT_PCIRST: begin
        if (!m_q.pcirst_s2) begin
          m_d.pcirst_seen = 1'b1;
        end else if (m_q.pcirst_seen) begin
          if (!m_q.strap_s2) begin
            m_d.st      = M_LOAD;
            m_d.start   = 1'b1;
            m_d.retry   = 1'b1;
            m_d.pin_mux = 1'b1;
          end else begin
            m_d.st        = M_DONE;
            m_d.load_done = 1'b1;
          end
        end
      end
      M_LOAD: begin
        if (m_q.tog_s2 != m_q.tog_prev) begin
          m_d.wr.valid  = 1'b1;
          m_d.wr.offset = m_q.idx;
          m_d.wr.data   = l_q.rx_byte;
          m_d.wr.dest   = dest_of(m_q.idx);
          m_d.wr.kind   = kind_of(m_q.idx);
          m_d.idx       = m_q.idx + 8'h01;
        end else if (m_q.done_s2) begin
          m_d.st        = M_DONE;
          m_d.start     = 1'b0;
          m_d.retry     = 1'b0;
          m_d.pin_mux   = 1'b0;
          m_d.load_done = 1'b1;
          m_d.load_err  = m_q.err_s2;
        end
      end
      // Terminal until global reset, so later PCI resets do nothing
      M_DONE:  m_d.st = M_DONE;
      default: m_d.st = M_DONE;
    endcase
    m_d.pcirst_s1 = pci_reset_n_in;
    m_d.pcirst_s2 = m_q.pcirst_s1;
    m_d.strap_s1  = rom_strap_pin_in;
    m_d.strap_s2  = m_q.strap_s1;
    m_d.done_s1   = l_q.done;
    m_d.done_s2   = m_q.done_s1;
    m_d.err_s1    = l_q.err;
    m_d.err_s2    = m_q.err_s1;
    m_d.tog_s1    = l_q.tog;
    m_d.tog_s2    = m_q.tog_s1;
    m_d.tog_prev  = m_q.tog_s2;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  // ----------------------------------------------------------------
  // Link clock side: two-wire bit engine
  // ----------------------------------------------------------------
  // Each bit is four quarter phases: low/set data, rise, high/sample,
  // fall. No clock stretching is honoured; the memory never needs it.
  always_comb begin
    logic tick;
    tick = (l_q.cnt == Q_LAST);
    l_d  = l_q;
    if (l_q.st != L_IDLE && l_q.st != L_END) begin
      l_d.cnt = tick ? 5'h00 : l_q.cnt + 5'h01;
      l_d.ph  = tick ? l_q.ph + 2'h1 : l_q.ph;
    end
    case (l_q.st)
      L_IDLE: begin
        if (l_q.go_s2) begin
          l_d.st    = L_START;
          l_d.cnt   = 5'h00;
          l_d.ph    = 2'h0;
          l_d.stage = 2'h0;
        end
      end
      L_START: begin
        if (tick) begin
          case (l_q.ph)
            2'h0: l_d.scl_oe = 1'b0;
            2'h1: l_d.sda_oe = 1'b1;
            2'h2: l_d.scl_oe = 1'b1;
            default: begin
              l_d.st   = L_TX;
              l_d.bitn = 4'h0;
              l_d.sh   = (l_q.stage == 2'h2) ? {ROM_DEV_ADDR, 1'b1}
                                             : {ROM_DEV_ADDR, 1'b0};
              l_d.sda_oe = ~ROM_DEV_ADDR[6];
            end
          endcase
        end
      end
      L_TX: begin
        if (tick) begin
          case (l_q.ph)
            2'h0, 2'h1: l_d.scl_oe = 1'b0;
            2'h2: begin
              l_d.scl_oe = 1'b1;
              if (l_q.bitn == 4'h8) begin
                l_d.ack_ok = ~l_q.sda_s2;
              end
            end
            default: begin
              if (l_q.bitn != 4'h8) begin
                l_d.bitn   = l_q.bitn + 4'h1;
                l_d.sh     = {l_q.sh[6:0], 1'b0};
                l_d.sda_oe = (l_q.bitn == 4'h7) ? 1'b0 : ~l_q.sh[6];
              end else if (!l_q.ack_ok) begin
                l_d.st     = L_STOP;
                l_d.err    = 1'b1;
                l_d.sda_oe = 1'b1;
              end else if (l_q.stage == 2'h0) begin
                // Word address 00h, then restart for sequential read
                l_d.stage  = 2'h1;
                l_d.bitn   = 4'h0;
                l_d.sh     = IMG_FIRST;
                l_d.sda_oe = ~IMG_FIRST[7];
              end else if (l_q.stage == 2'h1) begin
                l_d.st     = L_START;
                l_d.stage  = 2'h2;
                l_d.sda_oe = 1'b0;
              end else begin
                l_d.st     = L_RX;
                l_d.bitn   = 4'h0;
                l_d.sda_oe = 1'b0;
              end
            end
          endcase
        end
      end
      L_RX: begin
        if (tick) begin
          case (l_q.ph)
            2'h0, 2'h1: l_d.scl_oe = 1'b0;
            2'h2: begin
              l_d.scl_oe = 1'b1;
              if (l_q.bitn != 4'h8) begin
                l_d.sh = {l_q.sh[6:0], l_q.sda_s2};
              end
            end
            default: begin
              if (l_q.bitn == 4'h7) begin
                // Byte word is held for at least nine bit times past the toggle
                l_d.rx_byte = l_q.sh;
                l_d.tog     = ~l_q.tog;
                l_d.bitn    = 4'h8;
                l_d.sda_oe  = (l_q.idx != IMG_LAST);
              end else if (l_q.bitn == 4'h8) begin
                if (l_q.idx == IMG_LAST) begin
                  l_d.st     = L_STOP;
                  l_d.sda_oe = 1'b1;
                end else begin
                  l_d.idx    = l_q.idx + 8'h01;
                  l_d.bitn   = 4'h0;
                  l_d.sda_oe = 1'b0;
                end
              end else begin
                l_d.bitn = l_q.bitn + 4'h1;
              end
            end
          endcase
        end
      end
      L_STOP: begin
        if (tick) begin
          case (l_q.ph)
            2'h0: l_d.scl_oe = 1'b0;
            2'h1, 2'h2: l_d.sda_oe = 1'b0;
            default: begin
              l_d.st   = L_END;
              l_d.done = 1'b1;
            end
          endcase
        end
      end
      L_END:   l_d.st = L_END;
      default: l_d.st = L_IDLE;
    endcase
    if (l_q.rst_s2) begin
      l_d = '0;
    end
    l_d.rst_s1 = rst_in;
    l_d.rst_s2 = l_q.rst_s1;
    l_d.go_s1  = m_q.start;
    l_d.go_s2  = l_q.go_s1;
    l_d.sda_s1 = user_pin_4_in;
    l_d.sda_s2 = l_q.sda_s1;
  end
  always_ff @(posedge link_clk_in) begin
    l_q <= l_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open-drain: the level is always low, only the enable moves
  assign user_pin_3_out      = l_q.pin_lo;
  assign user_pin_3_oe_out   = l_q.scl_oe;
  assign user_pin_4_out      = l_q.pin_lo;
  assign user_pin_4_oe_out   = l_q.sda_oe;
  assign rom_pins_active_out = m_q.pin_mux;
  assign target_retry_out    = m_q.retry;
  assign load_done_out       = m_q.load_done;
  assign load_error_out      = m_q.load_err;
  assign cfg_write_out       = m_q.wr;
endmodule : serial_rom_config_loader

// *** bench/rom_loader_checker.sv ***
`timescale 1ns/10ps
module rom_loader_checker
  import rom_loader_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic       link_clk_in,
  input wire logic       user_pin_3_oe_out,
  input wire logic       user_pin_4_oe_out,
  input wire logic       rom_pins_active_out,
  input wire logic       target_retry_out,
  input wire logic       load_done_out,
  input wire cfg_write_t cfg_write_out
);
  // ----
  // Offset tracker
  // ----
  logic [7:0] next_q;
  logic       seen_q;
  logic       v;
  logic [7:0] o;
  assign v = cfg_write_out.valid;
  assign o = cfg_write_out.offset;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      next_q <= 8'h00;
      seen_q <= 1'b0;
    end else if (v) begin
      next_q <= o + 8'h01;
      seen_q <= 1'b1;
    end
  end
  sequence start_cond_s;
    $rose(user_pin_4_oe_out) && !user_pin_3_oe_out;
  endsequence
  sequence clock_pull_s;
    (!user_pin_3_oe_out)[*8] ##[8:10] user_pin_3_oe_out;
  endsequence
  start_hold_a: assert property (@(posedge link_clk_in)
    disable iff (rst_in) start_cond_s |-> clock_pull_s)
    else $error("clock pulled early after start");
  retry_write_a: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) v |-> target_retry_out && !load_done_out)
    else $error("write outside the load window");
  write_pulse_a: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) v |=> !v) else $error("write valid too long");
  first_ofs_a: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) v && !seen_q |-> o == IMG_FIRST)
    else $error("first offset wrong");
  next_ofs_a: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) v && seen_q |-> o == next_q && o <= IMG_LAST)
    else $error("offset out of order");
  link_dest_a: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) v && o < OFS_LINK_REGS |->
    cfg_write_out.dest == DEST_LINK_CFG &&
    (o > 8'h03 || cfg_write_out.kind == KIND_SUBSYS_ID))
    else $error("link field mapped wrong");
  guid_map_a: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) v && o[7:2] == 6'h0c |->
    cfg_write_out.kind == KIND_GUID_HIGH && cfg_write_out.dest == DEST_LINK_REG)
    else $error("unique id high mapped wrong");
  cap_map_a: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) v && o[7:2] == 6'h12 |->
    cfg_write_out.kind == KIND_CAPABILITY && cfg_write_out.dest == DEST_SD)
    else $error("capability mapped wrong");
  load_end_a: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) $fell(target_retry_out) |->
    load_done_out && !rom_pins_active_out) else $error("load ended badly");
  done_sticky_a: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) load_done_out |=> load_done_out && !target_retry_out)
    else $error("second load started");
endmodule : rom_loader_checker

bind serial_rom_config_loader rom_loader_checker i_chk (.ref_clk_in,
  .rst_in, .link_clk_in, .user_pin_3_oe_out, .user_pin_4_oe_out,
  .rom_pins_active_out, .target_retry_out, .load_done_out, .cfg_write_out);

// *** bench/rom_model.sv ***
`timescale 1ns/10ps
module rom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input  wire logic rst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic nack_in,
  output logic      sda_oe_out
);
  // ----
  // Serial memory, image byte = offset ^ a5
  // ----
  logic [7:0] sh_q  = 8'h00;
  logic [7:0] ptr_q = 8'h00;
  logic [7:0] b_q   = 8'h00;
  logic [1:0] st_q  = 2'd0;
  logic       rd_q  = 1'b0;
  int         cnt_q = 0;
  initial sda_oe_out = 1'b0;
  always @(posedge rst_in) begin
    st_q = 2'd0;
    sda_oe_out = 1'b0;
  end
  // Settle delay so a clock fall in the same step is not taken as start
  always @(negedge sda_in) begin
    #1;
    if (scl_in === 1'b1 && sda_in === 1'b0) begin
      st_q = 2'd1;
      cnt_q = 0;
    end
  end
  always @(posedge sda_in) begin
    #1;
    if (scl_in === 1'b1 && sda_in === 1'b1) st_q = 2'd0;
  end
  always @(posedge scl_in) begin
    if (st_q == 2'd3 && cnt_q == 8 && sda_in) st_q = 2'd0;
    else if (st_q != 2'd0 && cnt_q < 8) sh_q = {sh_q[6:0], sda_in};
    cnt_q = cnt_q + 1;
  end
  always @(negedge scl_in) begin
    if (st_q == 2'd3) begin
      if (cnt_q == 9) begin
        cnt_q = 0;
        ptr_q = ptr_q + 8'h01;
      end
      b_q = ptr_q ^ 8'ha5;
      sda_oe_out = (cnt_q < 8) && !b_q[7 - cnt_q];
    end else if (st_q != 2'd0 && cnt_q == 8) begin
      sda_oe_out = (st_q == 2'd2) || (sh_q[7:1] == DEV_ADDR && !nack_in);
      rd_q = sh_q[0];
      if (st_q == 2'd2) ptr_q = sh_q;
      if (!sda_oe_out) st_q = 2'd0;
    end else if (st_q != 2'd0 && cnt_q == 9) begin
      cnt_q = 0;
      st_q = (st_q == 2'd1) ? (rd_q ? 2'd3 : 2'd2) : 2'd0;
      b_q = ptr_q ^ 8'ha5;
      sda_oe_out = (st_q == 2'd3) && !b_q[7];
    end
  end
endmodule : rom_model

// *** bench/serial_rom_config_loader_tb.sv ***
`timescale 1ns/10ps
module serial_rom_config_loader_tb;
  import rom_loader_pkg::*;
  logic       ref_clk_in  = 1'b0;
  logic       link_clk_in = 1'b0;
  logic       rst_in      = 1'b1;
  logic       pci_n       = 1'b0;
  logic       strap       = 1'b0;
  logic       nack        = 1'b0;
  logic       d3, d4, oe3, oe4, pins, retry, done, err, rom_oe, scl, sda;
  cfg_write_t wr;
  int         n_mismatch  = 0;
  int         n_tests     = 0;
  int         n_wr        = 0;
  // ----
  // Clocks, wires, instances
  // ----
  always #4 ref_clk_in = ~ref_clk_in;
  // Odd start offset keeps link edges off every reference edge
  initial begin
    #1.3;
    forever #80 link_clk_in = ~link_clk_in;
  end
  assign scl = !oe3;
  assign sda = !(oe4 || rom_oe);
  always @(negedge ref_clk_in) if (wr.valid === 1'b1) n_wr <= n_wr + 1;
  serial_rom_config_loader i_dut (.ref_clk_in, .rst_in, .link_clk_in,
    .pci_reset_n_in(pci_n), .rom_strap_pin_in(strap), .user_pin_4_in(sda),
    .user_pin_3_out(d3), .user_pin_3_oe_out(oe3), .user_pin_4_out(d4),
    .user_pin_4_oe_out(oe4), .rom_pins_active_out(pins),
    .target_retry_out(retry), .load_done_out(done), .load_error_out(err),
    .cfg_write_out(wr));
  rom_model i_rom (.rst_in, .scl_in(scl), .sda_in(sda), .nack_in(nack),
    .sda_oe_out(rom_oe));
  // ----
  // Helpers
  // ----
  task automatic test_done();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_on(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge ref_clk_in);
      if (sel == 0 && retry === 1'b1) break;
      if (sel == 1 && done === 1'b1) break;
      if (sel == 2 && wr.valid === 1'b1) break;
    end
    if (i == lim) begin
      n_mismatch++;
      test_done();
    end
  endtask : wait_on
  // Link reset is synchronised, so reset spans link edges too
  task automatic start(input logic s, input logic n);
    @(negedge ref_clk_in);
    rst_in = 1'b1;
    pci_n = 1'b0;
    strap = s;
    nack = n;
    repeat (4) @(negedge link_clk_in);
    @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    pci_n = 1'b1;
  endtask : start
  task automatic pulse_pci();
    pci_n = 1'b0;
    repeat (10) @(negedge ref_clk_in);
    pci_n = 1'b1;
  endtask : pulse_pci
  // ----
  // Scenarios
  // ----
  task automatic t_load();
    start(1'b0, 1'b0);
    wait_on(0, 50);
    check({pins, done}, 2'b10);
    for (int k = 0; k < 2; k++) begin
      wait_on(2, 60000);
      check(wr, {1'b1, DEST_LINK_CFG, KIND_SUBSYS_ID, k[7:0],
                 k[7:0] ^ 8'ha5});
      check({retry, err}, 2'b10);
      if (k == 0) pulse_pci();
    end
  endtask : t_load
  task automatic t_nack();
    int base;
    start(1'b0, 1'b1);
    base = n_wr;
    wait_on(0, 50);
    check(pins, 1'b1);
    wait_on(1, 40000);
    check({retry, pins, err, oe3, oe4}, 5'b00100);
    check({d3, d4}, 2'b00);
    check(n_wr - base, 0);
  endtask : t_nack
  task automatic t_skip();
    int base;
    start(1'b1, 1'b0);
    base = n_wr;
    wait_on(1, 50);
    check({retry, pins}, 2'b00);
    pulse_pci();
    repeat (1000) @(negedge ref_clk_in);
    check({retry, done, oe3, oe4}, 4'b0100);
    check(n_wr - base, 0);
  endtask : t_skip
  initial begin
    t_load();
    t_nack();
    t_skip();
    test_done();
  end
endmodule : serial_rom_config_loader_tb
